//--- design/srm_exec.sv
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none

// Function
// - zero skip tests registers 4,1,2,3
// - nonzero skip tests registers 4,1,2,3
// - positive skip when bit 15 clear
// - negative skip when bit 15 set
// - taken skip jumps count plus one
// - decode decrement-repeat, zero form excluded
// - repeat jumps back by count, else next
// - decrement register, overflow like add, test sign
// - register codes 1..7 map 1,2,3,4,Q,A,I
// - decode transfer group, zero form excluded
// - op 0 copies low field into middle
// - decode misc group, zero form is nop
// - misc in unprotected mode raises violation
// - micromemory block load, Q words, regs 1,2
// - micro address: page, word, half select
// - block load interruptible, registers advance per word
// - register-set load from pointer plus 1..9
// - register-set load lowers pointer word by ten
// - register-set load resumes at address plus two
// - register-set store raises pointer first by ten
// - store registers and overflow at pointer 1..9
// - store clears overflow, resumes at plus two
module srm_exec (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // main memory
  output logic             mem_req,
  output logic             mem_we,
  output logic      [15:0] mem_addr,
  output logic      [15:0] mem_wdata,
  input  wire logic [15:0] mem_rdata,
  input  wire logic        mem_ack,
  // read/write micromemory
  output logic             umem_we,
  output logic      [12:0] umem_addr,
  output logic      [31:0] umem_wdata,
  // pause request from interrupt logic
  input  wire logic        intr_req
);

  // ***********************************************
  // state
  // ***********************************************
  srm_pkg::srm_state_t state;
  logic [15:0] rf [1:8];
  logic [15:0] pc;
  logic        ovf;
  logic        unprot;
  logic [15:0] ir;
  logic [15:0] ptra;
  logic [15:0] ptr;
  logic [3:0]  cnt;
  logic [15:0] hi;
  logic        st_viol;
  logic        st_paused;
  logic        st_other;
  logic        st_taken;

  // ***********************************************
  // decode
  // ***********************************************
  logic [3:0]  f_top;
  logic [3:0]  secondary_op_field;
  logic [3:0]  skip_op_field;
  logic [3:0]  skip_count;
  logic [2:0]  reg_field_a;
  logic [2:0]  reg_field_b;
  logic [1:0]  xfer_op_field;
  logic [3:0]  misc_op_field;
  logic        is_skip;
  logic        is_dr;
  logic        is_xfer;
  logic        is_misc;
  logic        dr_group_zero_form;
  logic        xfer_group_zero_form;
  logic [15:0] skip_val;
  logic        skip_take;
  logic [15:0] dr_val;
  logic [15:0] dr_new;
  logic [15:0] pc_next;
  logic [15:0] pc_skip;
  logic [15:0] pc_back;
  logic [15:0] pc_two;

  assign f_top              = ir[15:12];
  assign secondary_op_field = ir[11:8];
  assign skip_op_field      = ir[7:4];
  assign skip_count         = ir[3:0];
  assign reg_field_a        = ir[7:5];
  assign reg_field_b        = ir[2:0];
  assign xfer_op_field      = ir[4:3];
  assign misc_op_field      = ir[3:0];

  assign is_skip = (f_top == srm_pkg::GRP_TOP) && (secondary_op_field == srm_pkg::GRP_SKIP)
                   && (ir[7:0] != 8'h00);
  assign is_dr   = (f_top == srm_pkg::GRP_TOP) && (secondary_op_field == srm_pkg::GRP_DR)
                   && !ir[4] && ((reg_field_a != 3'h0) || (skip_count != 4'h0));
  assign dr_group_zero_form = (f_top == srm_pkg::GRP_TOP)
                   && (secondary_op_field == srm_pkg::GRP_DR) && !is_dr;
  assign is_xfer = (f_top == srm_pkg::GRP_TOP) && (secondary_op_field == srm_pkg::GRP_XFER)
                   && (ir[7:0] != 8'h00);
  assign xfer_group_zero_form = (f_top == srm_pkg::GRP_TOP)
                   && (secondary_op_field == srm_pkg::GRP_XFER) && !is_xfer;
  assign is_misc = (f_top == srm_pkg::GRP_TOP) && (secondary_op_field == srm_pkg::GRP_MISC)
                   && !ir[4] && ((reg_field_a != 3'h0) || (misc_op_field != 4'h0));

  assign skip_val = rf[srm_pkg::srm_skip_reg(skip_op_field[3:2])];

  always_comb begin
    case (skip_op_field[1:0])
      2'h0: skip_take = (skip_val == 16'h0000);
      2'h1: skip_take = (skip_val != 16'h0000);
      2'h2: skip_take = !skip_val[srm_pkg::SIGN_BIT];
      default: skip_take = skip_val[srm_pkg::SIGN_BIT];
    endcase
  end

  // register field code is the register file index
  assign dr_val  = (reg_field_a == 3'h0) ? 16'h0000 : rf[{1'b0, reg_field_a}];
  assign dr_new  = dr_val - 16'h0001;
  assign pc_next = pc + 16'h0001;
  assign pc_skip = pc + {12'h000, skip_count} + 16'h0001;
  assign pc_back = pc - {12'h000, skip_count};
  assign pc_two  = pc + 16'h0002;

  // ***********************************************
  // apb slave
  // ***********************************************
  logic apb_setup;
  logic apb_wr;
  logic mapped;

  assign apb_setup = psel && !penable;
  assign apb_wr    = psel && penable && pready && pwrite;
  assign mapped    = (paddr[1:0] == 2'h0) && (paddr <= srm_pkg::OFS_REGM);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (apb_setup) begin
        pslverr <= !mapped;
        prdata  <= 32'h0000_0000;
        if (paddr == srm_pkg::OFS_CTRL) begin
          prdata[srm_pkg::CTRL_UNPROT] <= unprot;
        end else if (paddr == srm_pkg::OFS_STATUS) begin
          prdata[srm_pkg::ST_BUSY]   <= (state != srm_pkg::S_IDLE);
          prdata[srm_pkg::ST_VIOL]   <= st_viol;
          prdata[srm_pkg::ST_PAUSED] <= st_paused;
          prdata[srm_pkg::ST_OTHER]  <= st_other;
          prdata[srm_pkg::ST_TAKEN]  <= st_taken;
        end else if (paddr == srm_pkg::OFS_PC) begin
          prdata[15:0] <= pc;
        end else if (paddr == srm_pkg::OFS_OVF) begin
          prdata[0] <= ovf;
        end else if (mapped) begin
          prdata[15:0] <= rf[paddr[5:2] - 4'h3];
        end
      end
    end
  end

  // ***********************************************
  // execution engine
  // ***********************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state      <= srm_pkg::S_IDLE;
      for (int i = 1; i <= 8; i++) begin
        rf[i] <= srm_pkg::RST_WORD;
      end
      pc         <= srm_pkg::RST_WORD;
      ovf        <= 1'b0;
      unprot     <= 1'b0;
      ir         <= srm_pkg::RST_WORD;
      ptra       <= srm_pkg::RST_WORD;
      ptr        <= srm_pkg::RST_WORD;
      cnt        <= 4'h0;
      hi         <= srm_pkg::RST_WORD;
      st_viol    <= 1'b0;
      st_paused  <= 1'b0;
      st_other   <= 1'b0;
      st_taken   <= 1'b0;
      mem_req    <= 1'b0;
      mem_we     <= 1'b0;
      mem_addr   <= srm_pkg::RST_WORD;
      mem_wdata  <= srm_pkg::RST_WORD;
      umem_we    <= 1'b0;
      umem_addr  <= 13'h0000;
      umem_wdata <= 32'h0000_0000;
    end else begin
      umem_we <= 1'b0;
      case (state)
        srm_pkg::S_IDLE: begin
          if (apb_wr) begin
            if (paddr == srm_pkg::OFS_CTRL) begin
              unprot <= pwdata[srm_pkg::CTRL_UNPROT];
              if (pwdata[srm_pkg::CTRL_GO]) begin
                st_viol   <= 1'b0;
                st_paused <= 1'b0;
                st_other  <= 1'b0;
                st_taken  <= 1'b0;
                state     <= srm_pkg::S_FETCH;
              end
            end else if (paddr == srm_pkg::OFS_PC) begin
              pc <= pwdata[15:0];
            end else if (paddr == srm_pkg::OFS_OVF) begin
              ovf <= pwdata[0];
            end else if (mapped && (paddr >= srm_pkg::OFS_REG1)) begin
              rf[paddr[5:2] - 4'h3] <= pwdata[15:0];
            end
          end
        end
        srm_pkg::S_FETCH: begin
          if (!mem_req) begin
            mem_req  <= 1'b1;
            mem_we   <= 1'b0;
            mem_addr <= pc;
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            ir      <= mem_rdata;
            state   <= srm_pkg::S_EXEC;
          end
        end
        srm_pkg::S_EXEC: begin
          state <= srm_pkg::S_IDLE;
          pc    <= pc_next;
          if (is_skip) begin
            st_taken <= skip_take;
            if (skip_take) begin
              pc <= pc_skip;
            end
          end else if (is_dr) begin
            if (reg_field_a != 3'h0) begin
              rf[{1'b0, reg_field_a}] <= dr_new;
              if (dr_val == 16'h8000) begin
                ovf <= 1'b1;
              end
              st_taken <= !dr_new[srm_pkg::SIGN_BIT];
              if (!dr_new[srm_pkg::SIGN_BIT]) begin
                pc <= pc_back;
              end
            end
          end else if (is_xfer) begin
            if ((xfer_op_field == srm_pkg::XFER_COPY) && (reg_field_a != 3'h0)
                && (reg_field_b != 3'h0)) begin
              rf[{1'b0, reg_field_a}] <= rf[{1'b0, reg_field_b}];
            end
          end else if (is_misc) begin
            if (unprot) begin
              st_viol <= 1'b1;
              pc      <= pc;
            end else if (reg_field_a == 3'h0) begin
              if (misc_op_field == srm_pkg::MISC_BLK) begin
                pc <= pc;
                if (rf[srm_pkg::REG_Q] == 16'h0000) begin
                  pc <= pc_next;
                end else begin
                  state <= srm_pkg::S_LMMH;
                end
              end else if ((misc_op_field == srm_pkg::MISC_LDR)
                           || (misc_op_field == srm_pkg::MISC_STR)) begin
                pc    <= pc;
                state <= srm_pkg::S_PTRA;
              end else begin
                st_other <= 1'b1;
              end
            end else begin
              st_other <= 1'b1;
            end
          end else begin
            st_other <= !(f_top == srm_pkg::GRP_TOP && secondary_op_field == srm_pkg::GRP_MISC)
                        || dr_group_zero_form || xfer_group_zero_form;
          end
        end
        srm_pkg::S_PTRA: begin
          if (!mem_req) begin
            mem_req  <= 1'b1;
            mem_we   <= 1'b0;
            mem_addr <= pc_next;
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            ptra    <= mem_rdata;
            state   <= srm_pkg::S_PTR;
          end
        end
        srm_pkg::S_PTR: begin
          if (!mem_req) begin
            mem_req  <= 1'b1;
            mem_we   <= 1'b0;
            mem_addr <= ptra;
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            cnt     <= 4'h1;
            if (misc_op_field == srm_pkg::MISC_LDR) begin
              ptr   <= mem_rdata;
              state <= srm_pkg::S_LDR;
            end else begin
              ptr   <= mem_rdata + srm_pkg::PTR_STEP;
              state <= srm_pkg::S_SRGP;
            end
          end
        end
        srm_pkg::S_LDR: begin
          if (!mem_req) begin
            mem_req  <= 1'b1;
            mem_we   <= 1'b0;
            mem_addr <= ptr + {12'h000, cnt};
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            cnt     <= cnt + 4'h1;
            if (cnt == srm_pkg::SET_WORDS) begin
              ovf   <= mem_rdata[srm_pkg::SIGN_BIT];
              state <= srm_pkg::S_LRGP;
            end else begin
              rf[cnt] <= mem_rdata;
            end
          end
        end
        srm_pkg::S_LRGP: begin
          if (!mem_req) begin
            mem_req   <= 1'b1;
            mem_we    <= 1'b1;
            mem_addr  <= ptra;
            mem_wdata <= ptr - srm_pkg::PTR_STEP;
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            mem_we  <= 1'b0;
            pc      <= pc_two;
            state   <= srm_pkg::S_IDLE;
          end
        end
        srm_pkg::S_SRGP: begin
          if (!mem_req) begin
            mem_req   <= 1'b1;
            mem_we    <= 1'b1;
            mem_addr  <= ptra;
            mem_wdata <= ptr;
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            mem_we  <= 1'b0;
            state   <= srm_pkg::S_STR;
          end
        end
        srm_pkg::S_STR: begin
          if (!mem_req) begin
            mem_req   <= 1'b1;
            mem_we    <= 1'b1;
            mem_addr  <= ptr + {12'h000, cnt};
            mem_wdata <= (cnt == srm_pkg::SET_WORDS) ? {ovf, 15'h0000} : rf[cnt];
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            mem_we  <= 1'b0;
            cnt     <= cnt + 4'h1;
            if (cnt == srm_pkg::SET_WORDS) begin
              ovf   <= 1'b0;
              pc    <= pc_two;
              state <= srm_pkg::S_IDLE;
            end
          end
        end
        srm_pkg::S_LMMH: begin
          if (!mem_req) begin
            mem_req  <= 1'b1;
            mem_we   <= 1'b0;
            mem_addr <= rf[srm_pkg::REG_2];
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            hi      <= mem_rdata;
            state   <= srm_pkg::S_LMML;
          end
        end
        srm_pkg::S_LMML: begin
          if (!mem_req) begin
            mem_req  <= 1'b1;
            mem_we   <= 1'b0;
            mem_addr <= rf[srm_pkg::REG_2] + 16'h0001;
          end else if (mem_ack) begin
            mem_req    <= 1'b0;
            umem_we    <= 1'b1;
            umem_addr  <= rf[srm_pkg::REG_1][12:0];
            umem_wdata <= {hi, mem_rdata};
            state      <= srm_pkg::S_UMW;
          end
        end
        srm_pkg::S_UMW: begin
          rf[srm_pkg::REG_1] <= rf[srm_pkg::REG_1] + 16'h0001;
          rf[srm_pkg::REG_2] <= rf[srm_pkg::REG_2] + 16'h0002;
          rf[srm_pkg::REG_Q] <= rf[srm_pkg::REG_Q] - 16'h0001;
          if (rf[srm_pkg::REG_Q] == 16'h0001) begin
            pc    <= pc_next;
            state <= srm_pkg::S_IDLE;
          end else if (intr_req) begin
            st_paused <= 1'b1;
            state     <= srm_pkg::S_IDLE;
          end else begin
            state <= srm_pkg::S_LMMH;
          end
        end
        default: begin
          state <= srm_pkg::S_IDLE;
        end
      endcase
    end
  end

  // ***********************************************
  // assertions
  // ***********************************************
  logic ex;
  assign ex = (state == srm_pkg::S_EXEC);

  property p_zero_skip;
    @(posedge pclk) disable iff (!presetn)
    (ex && is_skip && skip_op_field[1:0] == 2'h0
     && rf[srm_pkg::srm_skip_reg(skip_op_field[3:2])] == 16'h0000) |=> (pc == $past(pc_skip));
  endproperty
  a_zero_skip: assert property (p_zero_skip) else $error("zero skip not taken");

  property p_nz_skip;
    @(posedge pclk) disable iff (!presetn)
    (ex && is_skip && skip_op_field[1:0] == 2'h1 && skip_val == 16'h0000)
    |=> (pc == $past(pc_next));
  endproperty
  a_nz_skip: assert property (p_nz_skip) else $error("nonzero skip on zero");

  property p_pos_skip;
    @(posedge pclk) disable iff (!presetn)
    (ex && is_skip && skip_op_field[1:0] == 2'h2 && skip_val[15]) |=> !st_taken;
  endproperty
  a_pos_skip: assert property (p_pos_skip) else $error("positive skip on negative");

  property p_neg_skip;
    @(posedge pclk) disable iff (!presetn)
    (ex && is_skip && skip_op_field[1:0] == 2'h3 && skip_val[15]) |=> st_taken;
  endproperty
  a_neg_skip: assert property (p_neg_skip) else $error("negative skip missed");

  property p_repeat;
    @(posedge pclk) disable iff (!presetn)
    (ex && is_dr && reg_field_a != 3'h0 && !dr_new[15]) |=> (pc == $past(pc_back));
  endproperty
  a_repeat: assert property (p_repeat) else $error("repeat branch wrong");

  property p_viol;
    @(posedge pclk) disable iff (!presetn)
    (ex && is_misc && unprot) |=> (st_viol && pc == $past(pc) && state == srm_pkg::S_IDLE);
  endproperty
  a_viol: assert property (p_viol) else $error("privileged op not refused");

  property p_str_end;
    @(posedge pclk) disable iff (!presetn)
    (state == srm_pkg::S_STR && mem_req && mem_ack && cnt == srm_pkg::SET_WORDS)
    |=> (!ovf && pc == $past(pc_two));
  endproperty
  a_str_end: assert property (p_str_end) else $error("store end wrong");

  property p_ldr_ptr;
    @(posedge pclk) disable iff (!presetn)
    (state == srm_pkg::S_LRGP && mem_req) |-> (mem_we && mem_wdata == ptr - 16'h000a);
  endproperty
  a_ldr_ptr: assert property (p_ldr_ptr) else $error("pointer not lowered by ten");

  property p_blk_step;
    @(posedge pclk) disable iff (!presetn)
    (state == srm_pkg::S_UMW) |=> (rf[2] == $past(rf[2]) + 16'h0002);
  endproperty
  a_blk_step: assert property (p_blk_step) else $error("block load advance wrong");

  c_skip: cover property (@(posedge pclk) disable iff (!presetn) ex && is_skip && skip_take);
  c_rep:  cover property (@(posedge pclk) disable iff (!presetn) ex && is_dr && !dr_new[15]);
  c_ldr:  cover property (@(posedge pclk) disable iff (!presetn) state == srm_pkg::S_LRGP);
  c_blkp: cover property (@(posedge pclk) disable iff (!presetn)
                          state == srm_pkg::S_UMW && intr_req);

endmodule // srm_exec

`default_nettype wire

//--- inc/srm_pkg.sv
`default_nettype none
package srm_pkg;

  // ***********************************************
  // apb register map (byte addresses)
  // ***********************************************
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_PC     = 12'h008;
  localparam logic [11:0] OFS_OVF    = 12'h00c;
  localparam logic [11:0] OFS_REG1   = 12'h010;
  localparam logic [11:0] OFS_REGM   = 12'h02c;

  localparam int CTRL_GO     = 0;
  localparam int CTRL_UNPROT = 1;
  localparam int ST_BUSY     = 0;
  localparam int ST_VIOL     = 1;
  localparam int ST_PAUSED   = 2;
  localparam int ST_OTHER    = 3;
  localparam int ST_TAKEN    = 4;

  // ***********************************************
  // instruction encodings
  // ***********************************************
  localparam logic [3:0] GRP_TOP  = 4'h0;
  localparam logic [3:0] GRP_SKIP = 4'h0;
  localparam logic [3:0] GRP_DR   = 4'h6;
  localparam logic [3:0] GRP_XFER = 4'h7;
  localparam logic [3:0] GRP_MISC = 4'hb;
  localparam logic [1:0] XFER_COPY = 2'h0;
  localparam logic [3:0] MISC_BLK = 4'h1;
  localparam logic [3:0] MISC_LDR = 4'h2;
  localparam logic [3:0] MISC_STR = 4'h3;

  // register file indices: 1..7 follow the register field, m is 8
  localparam logic [3:0] REG_1 = 4'h1;
  localparam logic [3:0] REG_2 = 4'h2;
  localparam logic [3:0] REG_3 = 4'h3;
  localparam logic [3:0] REG_4 = 4'h4;
  localparam logic [3:0] REG_Q = 4'h5;
  localparam logic [3:0] REG_M = 4'h8;

  localparam logic [15:0] PTR_STEP   = 16'h000a;
  localparam logic [3:0]  SET_WORDS  = 4'h9;
  localparam logic [15:0] RST_WORD   = 16'h0000;
  localparam int          SIGN_BIT   = 15;

  typedef enum logic [3:0] {
    S_IDLE, S_FETCH, S_EXEC, S_PTRA, S_PTR, S_LDR, S_LRGP,
    S_SRGP, S_STR, S_LMMH, S_LMML, S_UMW
  } srm_state_t;

  // skip group: low op bits pick the test, high bits pick the register
  function automatic logic [3:0] srm_skip_reg(input logic [1:0] sel);
    case (sel)
      2'h0: srm_skip_reg = REG_4;
      2'h1: srm_skip_reg = REG_1;
      2'h2: srm_skip_reg = REG_2;
      default: srm_skip_reg = REG_3;
    endcase
  endfunction

endpackage
`default_nettype wire

//--- sim/srm_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// ***********************************************
// main memory and read/write micromemory
// ***********************************************
module srm_mem_model (
  // clock
  input  wire logic        pclk,
  // main memory
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [15:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  output logic      [15:0] mem_rdata,
  output logic             mem_ack,
  // micromemory
  input  wire logic        umem_we,
  input  wire logic [12:0] umem_addr,
  input  wire logic [31:0] umem_wdata,
  // answer delay select
  input  wire logic        slow
);
  logic [15:0] mem  [0:65535];
  logic [31:0] umem [0:8191];
  logic [2:0]  wait_cnt;
  logic        answer;
  assign answer = mem_req && !mem_ack && (wait_cnt >= (slow ? 3'h3 : 3'h0));
  always @(posedge pclk) begin
    // data is valid only in the ack cycle; otherwise the bus keeps changing
    mem_rdata <= (answer && !mem_we) ? mem[mem_addr] : ~mem_rdata;
    if (umem_we) umem[umem_addr] <= umem_wdata;
    if (mem_ack || !mem_req) begin
      mem_ack <= 1'b0;
      wait_cnt <= 3'h0;
    end else if (answer) begin
      mem_ack <= 1'b1;
      if (mem_we) mem[mem_addr] <= mem_wdata;
    end else wait_cnt <= wait_cnt + 3'h1;
  end
endmodule // srm_mem_model
`default_nettype wire

//--- sim/test_srm_exec.sv
`timescale 1ns/1ps
`default_nettype none
module test_srm_exec;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        mem_req, mem_we, mem_ack, umem_we, intr_req, slow;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, umem_wdata, st;
  logic [15:0] mem_addr, mem_wdata, mem_rdata;
  logic [12:0] umem_addr;
  logic [15:0] rv [0:3];
  int          n_mismatch, comparisons, cyc;
  srm_exec u_srm_exec (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .umem_we(umem_we),
    .umem_addr(umem_addr), .umem_wdata(umem_wdata), .intr_req(intr_req));
  srm_mem_model u_srm_mem_model (.pclk(pclk), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
    .umem_we(umem_we), .umem_addr(umem_addr), .umem_wdata(umem_wdata), .slow(slow));
  // ***********************************************
  // bus and compare tasks
  // ***********************************************
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    logic [31:0] q;
    apb(1'b1, a, {16'h0000, d}, q);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ckr(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  function automatic logic [11:0] rg(input int i);
    return srm_pkg::OFS_REG1 + 12'(4 * (i - 1));
  endfunction
  // execute one instruction at pc and wait until idle
  task automatic run(input logic [15:0] pc, input logic [15:0] ins, input logic up);
    u_srm_mem_model.mem[pc] = ins;
    wr(srm_pkg::OFS_PC, pc);
    wr(srm_pkg::OFS_CTRL, {14'h0, up, 1'b1});
    st = 32'h1;
    for (int i = 0; i < 300 && st[0] !== 1'b0; i++) apb(1'b0, srm_pkg::OFS_STATUS, 32'h0, st);
    if (st[0] !== 1'b0) n_mismatch++;
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ***********************************************
  // scenarios
  // ***********************************************
  task automatic t_skip();
    logic [15:0] v;
    logic        tk;
    rv = '{16'h0000, 16'h8000, 16'h0001, 16'hffff};
    for (int i = 0; i < 4; i++) wr(rg(i == 0 ? 4 : i), rv[i]);
    for (int op = 0; op < 16; op++) begin
      slow <= op[0];
      v = rv[op[3:2]];
      tk = (op[1:0] == 0) ? v == 0 : (op[1:0] == 1) ? v != 0 : (op[1:0] == 2) ? !v[15] : v[15];
      run(16'hfffe, {8'h00, 4'(op), 4'h3}, 1'b0);
      ckr(srm_pkg::OFS_PC, tk ? 32'h2 : 32'hffff);
    end
    $display("skip test done");
  endtask
  task automatic t_dr(input logic [15:0] q, input logic [15:0] pc, input logic [15:0] eq,
                      input logic [15:0] epc, input logic ov);
    wr(rg(5), q);
    wr(srm_pkg::OFS_OVF, 16'h0);
    run(pc, 16'h06a5, 1'b0);
    ckr(rg(5), {16'h0, eq});
    ckr(srm_pkg::OFS_PC, {16'h0, epc});
    ckr(srm_pkg::OFS_OVF, {31'h0, ov});
  endtask
  task automatic t_misc();
    logic [15:0] z [0:2];
    z = '{16'h0600, 16'h0700, 16'h0b00};
    for (int i = 0; i < 3; i++) begin
      run(16'h0020, z[i], 1'b0);
      ckr(srm_pkg::OFS_PC, 32'h21);
      chk(st[3], i < 2);
    end
    wr(rg(6), 16'h1234);
    run(16'h0020, 16'h0766, 1'b0);
    ckr(rg(3), 32'h1234);
    run(16'h0020, 16'h0b02, 1'b1);
    chk(st[1], 1'b1);
    ckr(srm_pkg::OFS_PC, 32'h20);
    $display("decode test done");
  endtask
  task automatic t_set();
    u_srm_mem_model.mem[16'h0031] = 16'h0100;
    u_srm_mem_model.mem[16'h0100] = 16'h0200;
    for (int i = 1; i < 9; i++) u_srm_mem_model.mem[16'h0200 + i] = 16'h1000 + 16'(i);
    u_srm_mem_model.mem[16'h0209] = 16'h9234;
    run(16'h0030, 16'h0b02, 1'b0);
    for (int i = 1; i < 9; i++) ckr(rg(i), 32'h1000 + i);
    ckr(srm_pkg::OFS_OVF, 32'h1);
    chk(u_srm_mem_model.mem[16'h0100], 16'h01f6);
    chk(u_srm_mem_model.mem[16'h0209], 16'h9234);
    ckr(srm_pkg::OFS_PC, 32'h32);
    u_srm_mem_model.mem[16'h0031] = 16'h0100;
    for (int i = 1; i < 10; i++) u_srm_mem_model.mem[16'h0200 + i] = 16'h0000;
    run(16'h0030, 16'h0b03, 1'b0);
    chk(u_srm_mem_model.mem[16'h0100], 16'h0200);
    for (int i = 1; i < 9; i++) chk(u_srm_mem_model.mem[16'h0200 + i], 16'h1000 + i);
    chk(u_srm_mem_model.mem[16'h0209], 16'h8000);
    ckr(srm_pkg::OFS_OVF, 32'h0);
    ckr(rg(8), 32'h1008);
    ckr(srm_pkg::OFS_PC, 32'h32);
    $display("register set test done");
  endtask
  task automatic t_blk();
    for (int i = 0; i < 4; i++) u_srm_mem_model.mem[16'h0300 + i] = 16'ha0b0 + 16'(i);
    wr(rg(5), 16'h2);
    wr(rg(1), 16'h1203);
    wr(rg(2), 16'h0300);
    intr_req <= 1'b1;
    run(16'h0050, 16'h0b01, 1'b0);
    chk(st[2], 1'b1);
    ckr(rg(5), 32'h1);
    ckr(srm_pkg::OFS_PC, 32'h50);
    intr_req <= 1'b0;
    run(16'h0050, 16'h0b01, 1'b0);
    ckr(rg(1), 32'h1205);
    ckr(rg(2), 32'h0304);
    ckr(rg(5), 32'h0);
    chk(u_srm_mem_model.umem[13'h1203], 32'ha0b0a0b1);
    chk(u_srm_mem_model.umem[13'h1204], 32'ha0b2a0b3);
    run(16'h0050, 16'h0b01, 1'b0);
    ckr(srm_pkg::OFS_PC, 32'h51);
    ckr(rg(1), 32'h1205);
    ckr(12'h030, 32'h0);
    chk(err, 1'b1);
    $display("block load test done");
  endtask
  // ***********************************************
  // clock, reset, sequence, timeout
  // ***********************************************
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 60000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; intr_req = 1'b0; slow = 1'b0; n_mismatch = 0; comparisons = 0; cyc = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_skip();
    t_dr(16'h0001, 16'h0002, 16'h0000, 16'hfffd, 1'b0);
    t_dr(16'h8000, 16'h0010, 16'h7fff, 16'h000b, 1'b1);
    t_dr(16'h0000, 16'h0010, 16'hffff, 16'h0011, 1'b0);
    $display("repeat test done");
    t_misc();
    t_set();
    t_blk();
    report_and_stop();
  end
endmodule // test_srm_exec
`default_nettype wire
